// ---- rtl/dvc_pkg.sv ----
package dvc_pkg;

   // ----------------------------------------
   // Widths and fixed-point format
   // ----------------------------------------
   localparam int NORM_W = 20;
   localparam int FRAC_W = 16;
   localparam int COEF_W = 16;
   localparam int X_W = 11;
   localparam int F_W = 24;
   localparam int ACC_W = 50;
   localparam int ROOT_W = 18;
   localparam int PT_AW = 5;
   localparam int PT_DEPTH = 20;

   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_LOW = 8'h04;
   localparam logic [7:0] REG_HIGH = 8'h08;
   localparam logic [7:0] REG_COUNT = 8'h0C;
   localparam logic [7:0] REG_PSEL = 8'h10;
   localparam logic [7:0] REG_PDATA = 8'h14;
   localparam logic [7:0] REG_NORM = 8'h18;
   localparam logic [7:0] REG_RESULT = 8'h1C;
   localparam logic [7:0] REG_STATUS = 8'h20;
   localparam logic [3:0] IDX_NONE = 4'hF;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int PDATA_X_LSB = 16;
   localparam int STATUS_BUSY_BIT = 0;
   localparam int STATUS_VALID_BIT = 1;

   // ----------------------------------------
   // Reset values and limits
   // ----------------------------------------
   localparam logic signed [15:0] LOW_RST = 16'sh0000;
   localparam logic signed [15:0] HIGH_RST = 16'sh03E8;
   localparam logic [4:0] PT_MIN = 5'h02;
   localparam logic [4:0] PT_MAX = 5'h14;
   localparam logic signed [11:0] X_FULL = 12'sh3E8;
   localparam logic signed [19:0] NORM_ONE = 20'sh1_0000;
   localparam logic signed [49:0] ROUND_HALF = 50'sh0_0000_0000_8000;
   localparam logic signed [15:0] DISP_MIN = 16'shFC19;
   localparam logic signed [15:0] DISP_MAX = 16'sh270F;
   localparam logic [4:0] ROOT_TOP = 5'h11;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      CHAR_LIN = 2'h0,
      CHAR_SQ = 2'h1,
      CHAR_ROOT = 2'h2,
      CHAR_USER = 2'h3
   } dvc_char_t;

   typedef enum logic [7:0] {
      S_IDLE = 8'h01,
      S_SQRT = 8'h02,
      S_SCALE = 8'h04,
      S_UWAIT = 8'h08,
      S_UREAD = 8'h10,
      S_UDIV = 8'h20,
      S_UDWAIT = 8'h40,
      S_FINISH = 8'h80
   } dvc_state_t;

   typedef struct packed {
      logic [X_W-1:0] x;
      logic signed [COEF_W-1:0] y;
   } dvc_point_t;

   typedef struct packed {
      dvc_state_t st;
      dvc_char_t mode;
      logic signed [COEF_W-1:0] low_scale_coeff;
      logic signed [COEF_W-1:0] high_scale_coeff;
      logic [PT_AW-1:0] cnt;
      logic [PT_AW-1:0] psel;
      logic signed [NORM_W-1:0] norm_sw;
      dvc_char_t op_mode;
      logic signed [NORM_W-1:0] op_norm;
      logic signed [COEF_W-1:0] op_low;
      logic signed [COEF_W-1:0] op_high;
      logic signed [F_W-1:0] f;
      logic signed [ACC_W-1:0] acc;
      logic [ROOT_W-1:0] root;
      logic [4:0] bitn;
      logic [PT_AW-1:0] j;
      dvc_point_t segment_low_point;
      dvc_point_t segment_high_point;
      logic div_start;
      logic div_neg;
      logic [ACC_W-1:0] div_num;
      logic [X_W-1:0] div_den;
      logic ahb_wr;
      logic [3:0] ahb_idx;
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
      logic signed [COEF_W-1:0] disp;
      logic done;
      logic busy;
      logic res_valid;
   } dvc_core_t;

endpackage

// ---- rtl/dvc_point_mem.sv ----
`timescale 1ns/1ps
module dvc_point_mem #(
   parameter int DEPTH = 20,
   parameter int AW = 5
) (
   input wire logic sys_clk,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire dvc_pkg::dvc_point_t wr_data,
   input wire logic [AW-1:0] rd_addr,
   output dvc_pkg::dvc_point_t rd_data
);

   dvc_pkg::dvc_point_t mem [DEPTH];

   // Registered read port, one cycle from address to data
   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end

endmodule

// ---- rtl/dvc_divider.sv ----
`timescale 1ns/1ps
module dvc_divider #(
   parameter int NUM_W = 50,
   parameter int DEN_W = 11
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic start,
   input wire logic [NUM_W-1:0] dividend,
   input wire logic [DEN_W-1:0] divisor,
   output logic done,
   output logic [NUM_W-1:0] quotient
);

   localparam int CW = $clog2(NUM_W + 1);

   typedef struct packed {
      logic busy;
      logic done;
      logic [CW-1:0] cnt;
      logic [DEN_W-1:0] den;
      logic [DEN_W-1:0] rem;
      logic [NUM_W-1:0] quo;
   } dvc_div_t;

   dvc_div_t q;
   dvc_div_t n;

   // Restoring division, one quotient bit per cycle
   always_comb begin
      logic [DEN_W:0] shifted;
      logic qbit;
      shifted = '0;
      qbit = 1'b0;
      n = q;
      n.done = 1'b0;
      if (start && !q.busy) begin
         n.busy = 1'b1;
         n.cnt = CW'(NUM_W);
         n.den = divisor;
         n.rem = '0;
         n.quo = dividend;
      end else if (q.busy) begin
         shifted = {q.rem, q.quo[NUM_W-1]};
         if (shifted >= {1'b0, q.den}) begin
            qbit = 1'b1;
            shifted = shifted - {1'b0, q.den};
         end
         n.rem = shifted[DEN_W-1:0];
         n.quo = {q.quo[NUM_W-2:0], qbit};
         n.cnt = q.cnt - CW'(1);
         if (q.cnt == CW'(1)) begin
            n.busy = 1'b0;
            n.done = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign done = q.done;
   assign quotient = q.quo;

endmodule

// ---- rtl/dvc_calc.sv ----
`timescale 1ns/1ps
// How it works
// - Linear: norm times coefficient span plus low
// - Low above high gives falling output
// - Square: squared norm, then linear scaling
// - Root: square root of norm, then scaling
// - Negative norm in root mode gives low
// - Curve holds two to twenty points
// - Pick segment whose points bracket norm
// - Segment interpolation with slope times thousand
// - Point X is thousandths of full scale
// - Outside points use outermost segment
module dvc_calc (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic meas_valid,
   input wire logic signed [19:0] meas_norm,
   output logic signed [15:0] disp_value,
   output logic disp_done,
   output logic busy
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [3:0] reg_index(input logic [31:0] a);
      if (a[31:6] == 26'h0 && a[1:0] == 2'h0 && a[5:2] <= dvc_pkg::REG_STATUS[5:2]) begin
         return a[5:2];
      end
      return dvc_pkg::IDX_NONE;
   endfunction

   function automatic logic signed [31:0] pt_pos(input dvc_pkg::dvc_point_t p);
      return $signed({5'h00, p.x, 16'h0000});
   endfunction

   function automatic logic signed [49:0] q16(input logic signed [15:0] v);
      return 50'(v) <<< dvc_pkg::FRAC_W;
   endfunction

   function automatic logic signed [15:0] round_sat(input logic signed [49:0] a);
      logic signed [49:0] r;
      r = (a + dvc_pkg::ROUND_HALF) >>> dvc_pkg::FRAC_W;
      if (r < dvc_pkg::DISP_MIN) begin
         return dvc_pkg::DISP_MIN;
      end
      if (r > dvc_pkg::DISP_MAX) begin
         return dvc_pkg::DISP_MAX;
      end
      return r[15:0];
   endfunction

   dvc_pkg::dvc_core_t q;
   dvc_pkg::dvc_core_t n;
   dvc_pkg::dvc_point_t rd_point;
   logic mem_we;
   logic div_done;
   logic [49:0] div_quot;
   logic signed [31:0] norm_x;

   // Norm in X units: 1000 per full scale, Q16
   assign norm_x = q.op_norm * dvc_pkg::X_FULL;
   assign mem_we = q.ahb_wr && q.ahb_idx == dvc_pkg::REG_PDATA[5:2] && q.psel < dvc_pkg::PT_MAX;

   // ----------------------------------------
   // Point table and divider
   // ----------------------------------------
   dvc_point_mem #(
      .DEPTH(dvc_pkg::PT_DEPTH),
      .AW(dvc_pkg::PT_AW)
   ) u_mem (
      .sys_clk(sys_clk),
      .wr_en(mem_we),
      .wr_addr(q.psel),
      .wr_data({hwdata[dvc_pkg::PDATA_X_LSB +: dvc_pkg::X_W], hwdata[15:0]}),
      .rd_addr(q.j),
      .rd_data(rd_point)
   );

   dvc_divider #(
      .NUM_W(dvc_pkg::ACC_W),
      .DEN_W(dvc_pkg::X_W)
   ) u_div (
      .sys_clk(sys_clk),
      .reset(reset),
      .start(q.div_start),
      .dividend(q.div_num),
      .divisor(q.div_den),
      .done(div_done),
      .quotient(div_quot)
   );

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic acc_ph;
      logic sw_start;
      logic start;
      logic signed [19:0] norm_in;
      logic signed [39:0] sq;
      logic signed [16:0] diff;
      logic [35:0] rad;
      logic [17:0] trial;
      logic advance;
      logic signed [11:0] den;
      logic signed [16:0] dy;
      logic signed [31:0] x_off;
      logic signed [49:0] num;
      logic signed [49:0] quot;
      acc_ph = hsel && htrans[1] && hready;
      sw_start = 1'b0;
      start = 1'b0;
      norm_in = '0;
      sq = '0;
      diff = '0;
      rad = '0;
      trial = '0;
      advance = 1'b0;
      den = '0;
      dy = '0;
      x_off = '0;
      num = '0;
      quot = '0;
      n = q;
      n.done = 1'b0;
      n.div_start = 1'b0;

      // Data phase of a write
      if (q.ahb_wr) begin
         case (q.ahb_idx)
            dvc_pkg::REG_CTRL[5:2]: begin
               n.mode = dvc_pkg::dvc_char_t'(hwdata[1:0]);
            end
            dvc_pkg::REG_LOW[5:2]: begin
               n.low_scale_coeff = hwdata[15:0];
            end
            dvc_pkg::REG_HIGH[5:2]: begin
               n.high_scale_coeff = hwdata[15:0];
            end
            dvc_pkg::REG_COUNT[5:2]: begin
               if (hwdata < 32'(dvc_pkg::PT_MIN)) begin
                  n.cnt = dvc_pkg::PT_MIN;
               end else if (hwdata > 32'(dvc_pkg::PT_MAX)) begin
                  n.cnt = dvc_pkg::PT_MAX;
               end else begin
                  n.cnt = hwdata[4:0];
               end
            end
            dvc_pkg::REG_PSEL[5:2]: begin
               n.psel = hwdata[4:0];
            end
            dvc_pkg::REG_PDATA[5:2]: begin
               if (mem_we) begin
                  n.psel = q.psel + 5'h01;
               end
            end
            dvc_pkg::REG_NORM[5:2]: begin
               n.norm_sw = hwdata[19:0];
               sw_start = 1'b1;
            end
            default: begin
            end
         endcase
      end

      // Address phase; read data registered for the data phase
      n.ahb_wr = acc_ph && hwrite;
      n.ahb_idx = reg_index(haddr);
      n.hrdata = '0;
      if (acc_ph && !hwrite) begin
         case (reg_index(haddr))
            dvc_pkg::REG_CTRL[5:2]: n.hrdata = {30'h0, q.mode};
            dvc_pkg::REG_LOW[5:2]: n.hrdata = 32'(q.low_scale_coeff);
            dvc_pkg::REG_HIGH[5:2]: n.hrdata = 32'(q.high_scale_coeff);
            dvc_pkg::REG_COUNT[5:2]: n.hrdata = {27'h0, q.cnt};
            dvc_pkg::REG_PSEL[5:2]: n.hrdata = {27'h0, q.psel};
            dvc_pkg::REG_NORM[5:2]: n.hrdata = 32'(q.norm_sw);
            dvc_pkg::REG_RESULT[5:2]: n.hrdata = 32'(q.disp);
            dvc_pkg::REG_STATUS[5:2]: n.hrdata = {30'h0, q.res_valid, q.busy};
            default: n.hrdata = '0;
         endcase
      end

      // Computation engine
      case (q.st)
         dvc_pkg::S_IDLE: begin
            start = meas_valid || sw_start;
            norm_in = meas_valid ? meas_norm : hwdata[19:0];
            sq = norm_in * norm_in;
            if (start) begin
               n.busy = 1'b1;
               n.res_valid = 1'b0;
               n.op_mode = q.mode;
               n.op_norm = norm_in;
               n.op_low = q.low_scale_coeff;
               n.op_high = q.high_scale_coeff;
               n.j = '0;
               case (q.mode)
                  dvc_pkg::CHAR_LIN: begin
                     n.f = 24'(norm_in);
                     n.st = dvc_pkg::S_SCALE;
                  end
                  dvc_pkg::CHAR_SQ: begin
                     n.f = sq[39:16];
                     n.st = dvc_pkg::S_SCALE;
                  end
                  dvc_pkg::CHAR_ROOT: begin
                     if (norm_in < 0) begin
                        n.acc = q16(q.low_scale_coeff);
                        n.st = dvc_pkg::S_FINISH;
                     end else begin
                        n.root = '0;
                        n.bitn = dvc_pkg::ROOT_TOP;
                        n.st = dvc_pkg::S_SQRT;
                     end
                  end
                  default: begin
                     n.st = dvc_pkg::S_UWAIT;
                  end
               endcase
            end
         end
         dvc_pkg::S_SQRT: begin
            // Bitwise root of norm scaled by 2^16, result stays Q16
            rad = {q.op_norm[15:0] == 16'h0 ? q.op_norm[19:0] : q.op_norm[19:0], 16'h0000};
            trial = q.root | (18'h0_0001 << q.bitn);
            if (36'(trial) * 36'(trial) <= rad) begin
               n.root = trial;
            end
            if (q.bitn == 5'h00) begin
               n.f = {6'h00, n.root};
               n.st = dvc_pkg::S_SCALE;
            end else begin
               n.bitn = q.bitn - 5'h01;
            end
         end
         dvc_pkg::S_SCALE: begin
            diff = 17'(q.op_high) - 17'(q.op_low);
            n.acc = q.f * diff + q16(q.op_low);
            n.st = dvc_pkg::S_FINISH;
         end
         dvc_pkg::S_UWAIT: begin
            n.st = dvc_pkg::S_UREAD;
         end
         dvc_pkg::S_UREAD: begin
            // Walk up while the next point still lies at or below the input
            advance = (q.j == 5'h00) || ((q.j < q.cnt - 5'h01) && (norm_x >= pt_pos(rd_point)));
            if (advance) begin
               n.segment_low_point = rd_point;
               n.j = q.j + 5'h01;
               n.st = dvc_pkg::S_UWAIT;
            end else begin
               n.segment_high_point = rd_point;
               n.st = dvc_pkg::S_UDIV;
            end
         end
         dvc_pkg::S_UDIV: begin
            den = $signed({1'b0, q.segment_high_point.x}) - $signed({1'b0, q.segment_low_point.x});
            dy = 17'(q.segment_high_point.y) - 17'(q.segment_low_point.y);
            x_off = norm_x - pt_pos(q.segment_low_point);
            num = x_off * dy;
            if (den == 12'sh000) begin
               n.acc = q16(q.segment_low_point.y);
               n.st = dvc_pkg::S_FINISH;
            end else begin
               n.div_neg = (num < 0) ^ (den < 0);
               n.div_num = (num < 0) ? 50'(-num) : 50'(num);
               n.div_den = (den < 0) ? 11'(-den) : 11'(den);
               n.div_start = 1'b1;
               n.st = dvc_pkg::S_UDWAIT;
            end
         end
         dvc_pkg::S_UDWAIT: begin
            if (div_done) begin
               quot = q.div_neg ? -$signed(div_quot) : $signed(div_quot);
               n.acc = quot + q16(q.segment_low_point.y);
               n.st = dvc_pkg::S_FINISH;
            end
         end
         dvc_pkg::S_FINISH: begin
            n.disp = round_sat(q.acc);
            n.done = 1'b1;
            n.busy = 1'b0;
            n.res_valid = 1'b1;
            n.st = dvc_pkg::S_IDLE;
         end
         default: begin
            n.st = dvc_pkg::S_IDLE;
            n.busy = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         q <= '0;
         q.st <= dvc_pkg::S_IDLE;
         q.mode <= dvc_pkg::CHAR_LIN;
         q.low_scale_coeff <= dvc_pkg::LOW_RST;
         q.high_scale_coeff <= dvc_pkg::HIGH_RST;
         q.cnt <= dvc_pkg::PT_MIN;
         q.hreadyout <= 1'b1;
      end else begin
         q <= n;
      end
   end

   assign hreadyout = q.hreadyout;
   assign hresp = q.hresp;
   assign hrdata = q.hrdata;
   assign disp_value = q.disp;
   assign disp_done = q.done;
   assign busy = q.busy;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   property p_lin_ends;
      disp_done && q.op_mode == dvc_pkg::CHAR_LIN && (q.op_norm == 0 || q.op_norm == dvc_pkg::NORM_ONE)
         |-> disp_value == round_sat(q16(q.op_norm == 0 ? q.op_low : q.op_high));
   endproperty
   a_lin_ends: assert property (p_lin_ends) else $error("linear end point wrong");

   property p_lin_inverted;
      disp_done && q.op_mode == dvc_pkg::CHAR_LIN && q.op_low > q.op_high && q.op_norm > 0
         |-> disp_value <= round_sat(q16(q.op_low));
   endproperty
   a_lin_inverted: assert property (p_lin_inverted) else $error("inverted line not falling");

   property p_sq_one;
      disp_done && q.op_mode == dvc_pkg::CHAR_SQ && q.op_norm == dvc_pkg::NORM_ONE
         |-> disp_value == round_sat(q16(q.op_high));
   endproperty
   a_sq_one: assert property (p_sq_one) else $error("square at one not high");

   property p_root_one;
      disp_done && q.op_mode == dvc_pkg::CHAR_ROOT && q.op_norm == dvc_pkg::NORM_ONE
         |-> disp_value == round_sat(q16(q.op_high));
   endproperty
   a_root_one: assert property (p_root_one) else $error("root at one not high");

   property p_root_neg;
      q.st == dvc_pkg::S_IDLE && meas_valid && q.mode == dvc_pkg::CHAR_ROOT && meas_norm < 0
         |-> ##2 disp_done && disp_value == round_sat(q16(q.op_low));
   endproperty
   a_root_neg: assert property (p_root_neg) else $error("negative root not low");

   property p_count_range;
      q.cnt >= dvc_pkg::PT_MIN && q.cnt <= dvc_pkg::PT_MAX;
   endproperty
   a_count_range: assert property (p_count_range) else $error("point count out of range");

   property p_bracket;
      q.st == dvc_pkg::S_UDIV |-> q.j >= 5'h01 && q.j <= q.cnt - 5'h01;
   endproperty
   a_bracket: assert property (p_bracket) else $error("segment index outside curve");

   property p_user_low_point;
      disp_done && q.op_mode == dvc_pkg::CHAR_USER && norm_x == pt_pos(q.segment_low_point)
         |-> disp_value == round_sat(q16(q.segment_low_point.y));
   endproperty
   a_user_low_point: assert property (p_user_low_point) else $error("value at low point wrong");

   property p_lin_latency;
      q.st == dvc_pkg::S_IDLE && meas_valid && q.mode == dvc_pkg::CHAR_LIN
         |=> busy ##1 busy ##1 disp_done && !busy;
   endproperty
   a_lin_latency: assert property (p_lin_latency) else $error("linear result late");

   property p_done_pulse;
      disp_done |=> !disp_done;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done longer than a cycle");

   property p_sat_range;
      disp_value >= dvc_pkg::DISP_MIN && disp_value <= dvc_pkg::DISP_MAX;
   endproperty
   a_sat_range: assert property (p_sat_range) else $error("display value out of range");

   c_user_done: cover property (disp_done && q.op_mode == dvc_pkg::CHAR_USER);
   c_root_done: cover property (disp_done && q.op_mode == dvc_pkg::CHAR_ROOT && q.op_norm > 0);
   c_saturated: cover property (disp_done && disp_value == dvc_pkg::DISP_MAX);

endmodule

// ---- verification/dvc_src_model.sv ----
`timescale 1ns/1ps
module dvc_src_model (
   input wire logic sys_clk,
   output logic meas_valid,
   output logic signed [19:0] meas_norm
);
   initial begin
      meas_valid = 1'b0;
      meas_norm = 20'h0_0000;
   end
   // One signed sample for one cycle, after a chosen idle gap
   task automatic send(input logic signed [19:0] n, input int gap);
      repeat (gap) @(posedge sys_clk);
      meas_valid <= 1'b1;
      meas_norm <= n;
      @(posedge sys_clk);
      meas_valid <= 1'b0;
      meas_norm <= ~n; // Stale sample is not left on the lines
   endtask
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   logic sys_clk = 0, reset = 1, hsel = 1, hwrite = 0, hready, hreadyout, hresp, meas_valid, disp_done, busy;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 0, hwdata = 0, hrdata;
   logic signed [19:0] meas_norm;
   logic signed [15:0] disp_value;
   int err_total = 0, check_count = 0, lo, hi, c;
   int px[4] = '{0, 300, 400, 900};
   int py[4] = '{-50, 30, 80, 900};
   int nl[5] = '{24576, -6144, 67584, 0, 65536};
   logic [7:0] ra[8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20, 8'h1C, 8'h24};
   int rv[8] = '{0, 0, 1000, 2, 0, 0, 0, 0};
   always #12.5 sys_clk = ~sys_clk;
   assign hready = hreadyout;
   dvc_calc dut (.sys_clk(sys_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .meas_valid(meas_valid), .meas_norm(meas_norm),
      .disp_value(disp_value), .disp_done(disp_done), .busy(busy));
   dvc_src_model src (.sys_clk(sys_clk), .meas_valid(meas_valid), .meas_norm(meas_norm));
   // ----------------------------------------
   // Checking and bus tasks
   // ----------------------------------------
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g, int tol);
      check_count++;
      if (^g === 1'bx || $signed(g - e) > tol || $signed(e - g) > tol) begin
         err_total++;
         $display("MISMATCH %s expected %0d seen %0d", nm, $signed(e), $signed(g));
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      haddr <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge sys_clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge sys_clk); while (hready !== 1'b1);
      r = hrdata;
      chk("hresp", 0, hresp, 0);
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      logic [31:0] r;
      ahb(1'b1, a, d, r);
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] e);
      logic [31:0] r;
      ahb(1'b0, a, 32'h0000_0000, r);
      chk($sformatf("reg %0h", a), e, r, 0);
   endtask
   task automatic cf(int l, int h);
      lo = l;
      hi = h;
      wr(8'h04, l);
      wr(8'h08, h);
   endtask
   // Expected display value for a mode and a Q16 sample
   function automatic int expv(int m, int n);
      real x, w;
      int k;
      x = n / 65536.0;
      k = 0;
      if (m == 3) begin
         for (int i = 1; i < 3; i++) if (px[i] * 65536 <= n * 1000) k = i;
         w = (x - px[k] / 1000.0) * (py[k+1] - py[k]) * 1000.0 / (px[k+1] - px[k]) + py[k];
      end else begin
         if (m == 1) x = x * x;
         if (m == 2) x = (n < 0) ? 0.0 : $sqrt(x);
         w = x * (hi - lo) + lo;
      end
      k = int'($floor(w + 0.5));
      return k < -999 ? -999 : (k > 9999 ? 9999 : k);
   endfunction
   task automatic waitd(output int n);
      n = 0;
      #1;
      chk("busy", 1, busy, 0);
      while (disp_done !== 1'b1 && n < 300) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      chk("done", 1, disp_done, 0);
      chk("busy", 0, busy, 0);
   endtask
   task automatic run(int m, int n);
      int e, t;
      e = expv(m, n);
      src.send(n[19:0], $urandom_range(0, 2));
      waitd(t);
      chk("disp", e, $signed(disp_value), (m == 0) ? 0 : 1);
      if (m < 2) chk("latency", 2, t, 0);
      if (m == 2 && n < 0) chk("latency", 1, t, 0);
      @(posedge sys_clk);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(32'h7e4e_4e10));
      repeat (16) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      foreach (ra[i]) rd(ra[i], rv[i]);
      cf(-300, 1200);
      for (int m = 0; m < 3; m++) begin
         wr(8'h00, m);
         foreach (nl[i]) run(m, nl[i]);
      end
      wr(8'h00, 0);
      cf(1200, -300);
      foreach (nl[i]) run(0, nl[i]);
      cf(0, 9999);
      run(0, 131072);
      run(0, -65536);
      wr(8'h0C, 25);
      rd(8'h0C, 20);
      wr(8'h0C, 1);
      rd(8'h0C, 2);
      wr(8'h0C, 4);
      wr(8'h10, 0);
      foreach (px[i]) wr(8'h14, {5'h00, 11'(px[i]), 16'(py[i])});
      wr(8'h00, 3);
      foreach (nl[i]) run(3, nl[i]);
      run(3, 19661);
      wr(8'h00, 0);
      wr(8'h18, 24576);
      waitd(c);
      @(posedge sys_clk);
      rd(8'h1C, expv(0, 24576));
      rd(8'h20, 2);
      repeat (24) begin
         c = $urandom_range(0, 2);
         cf($urandom_range(0, 10998) - 999, $urandom_range(0, 10998) - 999);
         wr(8'h00, c);
         run(c, $urandom_range(0, 163840) - 32768);
      end
      tally_and_finish;
   end
   initial begin
      #1000000;
      err_total++;
      tally_and_finish;
   end
endmodule
